// File: common/msq_regs.svh
`ifndef MSQ_REGS_SVH
`define MSQ_REGS_SVH

// ----------------------------------------
// sequencer counts
// ----------------------------------------
`define MSQ_CNT_ZERO       11'h000
`define MSQ_CNT_FIRST      11'h001
`define MSQ_CNT_LAST       11'h7FF
`define MSQ_START_CLR_CNT  11'h005
`define MSQ_INT_START_60   11'h070
`define MSQ_INT_START_50   11'h002
`define MSQ_INT_LEN_60     11'h222
`define MSQ_INT_LEN_50     11'h28F
`define MSQ_DE_END_0       11'h528
`define MSQ_DE_END_1       11'h5C6
`define MSQ_DE_END_2       11'h664
`define MSQ_DE_END_3       11'h702
`define MSQ_X8_LEN         11'h008
`define MSQ_LAST_DEINT     2'h3
`define MSQ_CONV_LEN       12'h800

// ----------------------------------------
// results counter
// ----------------------------------------
`define MSQ_STEP_0         20'h0_0200
`define MSQ_STEP_1         20'h0_0040
`define MSQ_STEP_2         20'h0_0008
`define MSQ_STEP_3         20'h0_0001
`define MSQ_SAT_MAX        20'h5_58E8
`define MSQ_RES_ZERO       20'h0_0000

// ----------------------------------------
// command frame fields
// ----------------------------------------
`define MSQ_CMD_AUX        0
`define MSQ_CMD_START      7
`define MSQ_CMD_LINE       6
`define MSQ_CMD_SLEEP      5
`define MSQ_CMD_RZERO      4
`define MSQ_CMD_RS0        2
`define MSQ_CMD_RS1        1
`define MSQ_AUX_GP0        4
`define MSQ_AUX_GP1        5
`define MSQ_AUX_GP2        6
`define MSQ_AUX_GP3        7

// ----------------------------------------
// readout select and layout
// ----------------------------------------
`define MSQ_SEL_LOW        2'h0
`define MSQ_SEL_HIGH       2'h1
`define MSQ_SEL_STATUS     2'h2
`define MSQ_INVALID_BYTE   8'h00
`define MSQ_BIT_LAST       3'h7

`endif

// File: common/msq_pkg.sv
package msq_pkg;

	typedef enum logic [4:0] {
		MSQ_ZERO   = 5'b0_0001,
		MSQ_INTEG  = 5'b0_0010,
		MSQ_DEINT  = 5'b0_0100,
		MSQ_REST   = 5'b0_1000,
		MSQ_TIMES8 = 5'b1_0000
	} msq_phase_t;

endpackage

// File: verilog/msq_sequencer.sv
// What this block does
// - sleep bit: sleep when EOC next rises
// - asleep: sequencer frozen, serial port still works
// - line bit picks 546 or 655 counts
// - start bit runs exactly one conversion
// - 2048 counts; EOC set 0000, cleared 0001
// - start sampled only at count 0000
// - start bit clears five clocks after launch
// - start written mid-conversion is held
// - aux command drives gp outputs 0..3
// - result is raw offset plus input
// - low byte holds result bits 3..10
// - high byte holds bits 11..18 twos-complement
// - status holds bits 0..2, refreshed per conversion
// - integrating flag follows integrate phase
// - EOC parks sequencer at 0000, zero-integrate
// - result update during frame sets collision
// - reading status clears collision
// - fixed phase starts, deintegrate ends on crossing
// - up/down counter steps 512, 64, 8, 1
// - counter copied to result at conversion end
// - 8-bit MSB-first frames, commit on CS rise
// - readout select applies to next frame
// - status order: coll,eoc,int,sleep,neg,b2..b0
// - result saturates at +-350440
`include "msq_regs.svh"

module msq_sequencer #(
	parameter int RES_W = 20
) (
	input  wire logic clock_i,
	input  wire logic rstn_i,
	input  wire logic sclk_i,
	input  wire logic cs_n_i,
	input  wire logic din_i,
	input  wire logic comp_i,
	output logic      dout_o,
	output logic      eoc_o,
	output logic      integrating_o,
	output logic      osc_run_o,
	output logic      read_zero_o,
	output logic      gp_output_0_o,
	output logic      gp_output_1_o,
	output logic      gp_output_2_o,
	output logic      gp_output_3_o
);

	if (RES_W != 20) begin : g_res_w_check
		$error("msq_sequencer: RES_W must be 20");
	end

	// ----------------------------------------
	// link side (shift clock domain)
	// ----------------------------------------
	logic       link_rst_n;
	logic [2:0] bit_cnt;
	logic [7:0] rx_shift;
	logic [7:0] tx_word;

	assign link_rst_n = rstn_i & ~cs_n_i;

	always_ff @(posedge sclk_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt <= 3'h0;
		end else begin
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	always_ff @(posedge sclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_shift <= 8'h00;
		end else if (!cs_n_i) begin
			rx_shift <= {rx_shift[6:0], din_i};
		end
	end

	always_ff @(negedge sclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dout_o <= 1'b0;
		end else begin
			dout_o <= tx_word[`MSQ_BIT_LAST - bit_cnt];
		end
	end

	// ----------------------------------------
	// crossing into oscillator domain
	// ----------------------------------------
	logic cs_s1, cs_s2, cs_d;
	logic comp_s1, comp_s2;
	logic commit, frame_open;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cs_s1   <= 1'b1;
			cs_s2   <= 1'b1;
			cs_d    <= 1'b1;
			comp_s1 <= 1'b0;
			comp_s2 <= 1'b0;
		end else begin
			cs_s1   <= cs_n_i;
			cs_s2   <= cs_s1;
			cs_d    <= cs_s2;
			comp_s1 <= comp_i;
			comp_s2 <= comp_s1;
		end
	end

	assign commit     = cs_s2 & ~cs_d;
	assign frame_open = ~cs_s2 & cs_d;

	// ----------------------------------------
	// command registers
	// ----------------------------------------
	logic       wr_cmd, wr_aux, wr_start;
	logic       start_bit, line50, sleep_bit;
	logic [1:0] rs_sel;
	logic [10:0] seq_cnt;
	logic       asleep;

	assign wr_cmd   = commit & ~rx_shift[`MSQ_CMD_AUX];
	assign wr_aux   = commit & rx_shift[`MSQ_CMD_AUX];
	assign wr_start = wr_cmd & rx_shift[`MSQ_CMD_START];

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			line50      <= 1'b0;
			sleep_bit   <= 1'b0;
			read_zero_o <= 1'b0;
			rs_sel      <= `MSQ_SEL_LOW;
		end else if (wr_cmd) begin
			line50      <= rx_shift[`MSQ_CMD_LINE];
			sleep_bit   <= rx_shift[`MSQ_CMD_SLEEP];
			read_zero_o <= rx_shift[`MSQ_CMD_RZERO];
			rs_sel      <= {rx_shift[`MSQ_CMD_RS1], rx_shift[`MSQ_CMD_RS0]};
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gp_output_0_o <= 1'b0;
			gp_output_1_o <= 1'b0;
			gp_output_2_o <= 1'b0;
			gp_output_3_o <= 1'b0;
		end else if (wr_aux) begin
			gp_output_0_o <= rx_shift[`MSQ_AUX_GP0];
			gp_output_1_o <= rx_shift[`MSQ_AUX_GP1];
			gp_output_2_o <= rx_shift[`MSQ_AUX_GP2];
			gp_output_3_o <= rx_shift[`MSQ_AUX_GP3];
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			start_bit <= 1'b0;
		end else if (wr_start) begin
			start_bit <= 1'b1;
		end else if (seq_cnt == `MSQ_START_CLR_CNT && !asleep) begin
			start_bit <= 1'b0;
		end
	end

	// ----------------------------------------
	// sequence counter
	// ----------------------------------------
	logic launch, conv_end;

	// start looked at only at 0000
	assign launch   = (seq_cnt == `MSQ_CNT_ZERO) & start_bit & ~asleep;
	assign conv_end = (seq_cnt == `MSQ_CNT_LAST) & ~asleep;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			seq_cnt <= `MSQ_CNT_ZERO;
		end else if (launch || (seq_cnt != `MSQ_CNT_ZERO && !asleep)) begin
			seq_cnt <= seq_cnt + `MSQ_CNT_FIRST;
		end
	end

	// eoc at 0000, off at 0001
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			eoc_o <= 1'b1;
		end else if (conv_end) begin
			eoc_o <= 1'b1;
		end else if (launch) begin
			eoc_o <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			asleep    <= 1'b0;
			osc_run_o <= 1'b1;
		end else if (conv_end && sleep_bit) begin
			asleep    <= 1'b1;
			osc_run_o <= 1'b0;
		end else if (!sleep_bit) begin
			asleep    <= 1'b0;
			osc_run_o <= 1'b1;
		end
	end

	// ----------------------------------------
	// phase sequencer
	// ----------------------------------------
	msq_pkg::msq_phase_t phase;
	logic        line_cur, deint_up, crossed;
	logic [1:0]  deint_idx;
	logic [10:0] int_start, int_end, de_end;
	logic [19:0] step;

	assign int_start = line_cur ? `MSQ_INT_START_50 : `MSQ_INT_START_60;
	assign int_end   = int_start + (line_cur ? `MSQ_INT_LEN_50 : `MSQ_INT_LEN_60);
	assign crossed   = comp_s2 != deint_up;

	always_comb begin
		de_end = `MSQ_DE_END_0;
		step   = `MSQ_STEP_0;
		unique case (deint_idx)
			2'h0: begin de_end = `MSQ_DE_END_0; step = `MSQ_STEP_0; end
			2'h1: begin de_end = `MSQ_DE_END_1; step = `MSQ_STEP_1; end
			2'h2: begin de_end = `MSQ_DE_END_2; step = `MSQ_STEP_2; end
			2'h3: begin de_end = `MSQ_DE_END_3; step = `MSQ_STEP_3; end
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			line_cur <= 1'b0;
		end else if (launch) begin
			line_cur <= line50;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phase     <= msq_pkg::MSQ_ZERO;
			deint_idx <= 2'h0;
			deint_up  <= 1'b0;
		end else begin
			unique case (phase)
				msq_pkg::MSQ_ZERO: begin
					if (seq_cnt == int_start) begin
						phase <= msq_pkg::MSQ_INTEG;
					end
				end
				msq_pkg::MSQ_INTEG: begin
					if (seq_cnt == int_end) begin
						phase     <= msq_pkg::MSQ_DEINT;
						deint_idx <= 2'h0;
						deint_up  <= comp_s2;
					end
				end
				msq_pkg::MSQ_DEINT, msq_pkg::MSQ_REST: begin
					if (seq_cnt == de_end) begin
						phase <= (deint_idx == `MSQ_LAST_DEINT) ? msq_pkg::MSQ_ZERO
							: msq_pkg::MSQ_TIMES8;
					end else if (phase == msq_pkg::MSQ_DEINT && crossed) begin
						phase <= msq_pkg::MSQ_REST;
					end
				end
				msq_pkg::MSQ_TIMES8: begin
					if (seq_cnt == de_end + `MSQ_X8_LEN) begin
						phase     <= msq_pkg::MSQ_DEINT;
						deint_idx <= deint_idx + 2'h1;
						deint_up  <= comp_s2;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			integrating_o <= 1'b0;
		end else if (phase == msq_pkg::MSQ_ZERO && seq_cnt == int_start) begin
			integrating_o <= 1'b1;
		end else if (phase == msq_pkg::MSQ_INTEG && seq_cnt == int_end) begin
			integrating_o <= 1'b0;
		end
	end

	// ----------------------------------------
	// results counter and result register
	// ----------------------------------------
	logic signed [20:0] next_acc;
	logic signed [19:0] acc, result;

	always_comb begin
		next_acc = deint_up ? (21'(acc) + 21'(signed'(step))) : (21'(acc) - 21'(signed'(step)));
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			acc <= `MSQ_RES_ZERO;
		end else if (launch) begin
			acc <= `MSQ_RES_ZERO;
		end else if (phase == msq_pkg::MSQ_DEINT && !crossed && seq_cnt != de_end) begin
			if (next_acc > 21'(signed'(`MSQ_SAT_MAX))) begin
				acc <= `MSQ_SAT_MAX;
			end else if (next_acc < -21'(signed'(`MSQ_SAT_MAX))) begin
				acc <= -`MSQ_SAT_MAX;
			end else begin
				acc <= next_acc[19:0];
			end
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			result <= `MSQ_RES_ZERO;
		end else if (conv_end) begin
			result <= acc;
		end
	end

	// ----------------------------------------
	// readout and collision
	// ----------------------------------------
	logic [1:0] frame_sel;
	logic       coll_pend, collision;
	logic [7:0] status_byte;

	assign status_byte = {collision, eoc_o, integrating_o, asleep, result[19], result[2:0]};

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_word   <= `MSQ_INVALID_BYTE;
			frame_sel <= `MSQ_SEL_LOW;
		end else if (frame_open) begin
			frame_sel <= rs_sel;
			unique case (rs_sel)
				`MSQ_SEL_LOW:    tx_word <= result[10:3];
				`MSQ_SEL_HIGH:   tx_word <= result[18:11];
				`MSQ_SEL_STATUS: tx_word <= status_byte;
				default:         tx_word <= `MSQ_INVALID_BYTE;
			endcase
		end
	end

	// set on CS rise wins over clear
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			coll_pend <= 1'b0;
			collision <= 1'b0;
		end else if (commit) begin
			coll_pend <= 1'b0;
			if (coll_pend || conv_end) begin
				collision <= 1'b1;
			end else if (frame_sel == `MSQ_SEL_STATUS) begin
				collision <= 1'b0;
			end
		end else if (conv_end && !cs_s2) begin
			coll_pend <= 1'b1;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [10:0] int_cyc;
	logic [11:0] run_cyc;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			int_cyc <= 11'h000;
		end else if (phase == msq_pkg::MSQ_INTEG) begin
			int_cyc <= int_cyc + 11'h001;
		end else if (phase == msq_pkg::MSQ_ZERO) begin
			int_cyc <= 11'h000;
		end
	end

	// cycles from launch up to the eoc rise
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run_cyc <= 12'h000;
		end else if (launch) begin
			run_cyc <= 12'h001;
		end else if (!eoc_o) begin
			run_cyc <= run_cyc + 12'h001;
		end
	end

	AST_SLEEP_ENTRY: assert property (@(posedge clock_i) disable iff (!rstn_i)
		conv_end && sleep_bit |=> asleep && eoc_o && !osc_run_o)
		else $error("sleep not entered at eoc rise");
	AST_SLEEP_FREEZE: assert property (@(posedge clock_i) disable iff (!rstn_i)
		asleep && sleep_bit |=> $stable(seq_cnt) && eoc_o)
		else $error("sequencer moved while asleep");
	AST_INT_LEN: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$fell(integrating_o) |-> int_cyc == (line_cur ? `MSQ_INT_LEN_50 : `MSQ_INT_LEN_60))
		else $error("integrate length wrong");
	AST_PARK: assert property (@(posedge clock_i) disable iff (!rstn_i)
		eoc_o && !start_bit |=> seq_cnt == `MSQ_CNT_ZERO && phase == msq_pkg::MSQ_ZERO)
		else $error("sequencer left 0000 without start");
	AST_LAUNCH: assert property (@(posedge clock_i) disable iff (!rstn_i)
		seq_cnt == `MSQ_CNT_ZERO && start_bit && !asleep
		|=> seq_cnt == `MSQ_CNT_FIRST && !eoc_o)
		else $error("conversion launch wrong");
	AST_CONV_LEN: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$rose(eoc_o) |-> run_cyc == `MSQ_CONV_LEN && seq_cnt == `MSQ_CNT_ZERO)
		else $error("conversion length wrong");
	AST_START_CLR: assert property (@(posedge clock_i) disable iff (!rstn_i)
		launch && !wr_start ##1 !wr_start [*5] |=> !start_bit)
		else $error("start bit not cleared after five clocks");
	AST_ONE_SHOT: assert property (@(posedge clock_i) disable iff (!rstn_i)
		conv_end && !start_bit ##1 !start_bit [*8] |-> eoc_o)
		else $error("conversion repeated without start");
	AST_GP_OUT: assert property (@(posedge clock_i) disable iff (!rstn_i)
		wr_aux |=> {gp_output_3_o, gp_output_2_o, gp_output_1_o, gp_output_0_o}
			== $past(rx_shift[7:4]))
		else $error("gp outputs not loaded");
	AST_RES_COPY: assert property (@(posedge clock_i) disable iff (!rstn_i)
		conv_end |=> result == $past(acc))
		else $error("result not copied at conversion end");
	AST_SAT: assert property (@(posedge clock_i) disable iff (!rstn_i)
		acc <= signed'(`MSQ_SAT_MAX) && acc >= -signed'(`MSQ_SAT_MAX))
		else $error("results counter beyond hard limit");
	AST_COLL_SET: assert property (@(posedge clock_i) disable iff (!rstn_i)
		commit && (coll_pend || conv_end) |=> collision)
		else $error("collision not set at frame end");
	AST_COLL_PEND: assert property (@(posedge clock_i) disable iff (!rstn_i)
		conv_end && !cs_s2 && !commit |=> coll_pend)
		else $error("collision pending lost");
	AST_COLL_CLR: assert property (@(posedge clock_i) disable iff (!rstn_i)
		commit && frame_sel == `MSQ_SEL_STATUS && !coll_pend && !conv_end |=> !collision)
		else $error("status read did not clear collision");
	AST_STEP_DIR: assert property (@(posedge clock_i) disable iff (!rstn_i)
		phase == msq_pkg::MSQ_DEINT && !crossed && seq_cnt != de_end && deint_idx == 2'h3
		&& acc < signed'(`MSQ_SAT_MAX) && acc > -signed'(`MSQ_SAT_MAX)
		|=> acc == $past(acc) + ($past(deint_up) ? 20'sh0_0001 : -20'sh0_0001))
		else $error("fourth phase step wrong");

	COV_CONVERSION: cover property (@(posedge clock_i) disable iff (!rstn_i) conv_end ##1 eoc_o);
	COV_COLLISION: cover property (@(posedge clock_i) disable iff (!rstn_i) $rose(collision));
	COV_SLEEP: cover property (@(posedge clock_i) disable iff (!rstn_i) $rose(asleep));
	COV_CROSS: cover property (@(posedge clock_i) disable iff (!rstn_i)
		phase == msq_pkg::MSQ_DEINT && crossed);

endmodule

// File: dv/msq_host_model.sv
// ----------------------------------------
// host side of the serial link
// ----------------------------------------
module msq_host_model #(
	parameter real HALF_NS  = 62.5,
	parameter real SETUP_NS = 40.0,
	parameter real GAP_NS   = 100.0
) (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      din_o,
	input  wire logic dout_i
);
	timeunit 1ns;
	timeprecision 100ps;

	// link clock idles high, stands still between frames
	initial begin
		sclk_o = 1'h1;
		cs_n_o = 1'h1;
		din_o  = 1'h0;
	end

	task automatic xfer(input logic [7:0] cmd, output logic [7:0] rd);
		cs_n_o = 1'h0;
		#(SETUP_NS);
		for (int k = 7; k >= 0; k--) begin
			sclk_o = 1'h0;
			din_o = cmd[k];
			#(HALF_NS);
			sclk_o = 1'h1;
			rd[k] = dout_i;
			#(HALF_NS);
		end
		cs_n_o = 1'h1;
		din_o = ~din_o;
		#(GAP_NS);
	endtask
endmodule

// File: dv/msq_sequencer_tb.sv
module msq_sequencer_tb;
	timeunit 1ns;
	timeprecision 100ps;

`define CHECK(what, exp, got) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) begin \
			n_mismatch++; \
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got); \
		end \
	end

	localparam int SAT = 350440;

	logic        clock_i;
	logic        rstn_i;
	logic        comp_i;
	logic        sclk;
	logic        cs_n;
	logic        din;
	logic        dout;
	logic        eoc;
	logic        integ;
	logic        osc_run;
	logic        read_zero;
	logic [3:0]  gp;
	logic [7:0]  rd;
	logic [7:0]  st;
	logic [19:0] pos;
	logic [19:0] neg;
	logic [19:0] res;
	int          n_mismatch;
	int          n_compared;
	int          eoc_lo;
	int          int_hi;

	msq_sequencer msq_sequencer_i (
		.clock_i       (clock_i),
		.rstn_i        (rstn_i),
		.sclk_i        (sclk),
		.cs_n_i        (cs_n),
		.din_i         (din),
		.comp_i        (comp_i),
		.dout_o        (dout),
		.eoc_o         (eoc),
		.integrating_o (integ),
		.osc_run_o     (osc_run),
		.read_zero_o   (read_zero),
		.gp_output_0_o (gp[0]),
		.gp_output_1_o (gp[1]),
		.gp_output_2_o (gp[2]),
		.gp_output_3_o (gp[3])
	);

	msq_host_model msq_host_model_i (
		.sclk_o (sclk),
		.cs_n_o (cs_n),
		.din_o  (din),
		.dout_i (dout)
	);

	initial begin
		clock_i = 1'h0;
		forever #4 clock_i = ~clock_i;
	end

	// ----------------------------------------
	// cycle counters for phase lengths
	// ----------------------------------------
	always @(posedge clock_i) begin
		if (eoc === 1'h0) eoc_lo++;
		if (integ === 1'h1) int_hi++;
	end

	task automatic sx(input logic [7:0] c);
		msq_host_model_i.xfer(c, rd);
	endtask

	task automatic wait_eoc(input logic v, input int lim);
		for (int i = 0; i < lim && eoc !== v; i++) begin
			@(posedge clock_i);
			#1;
		end
		`CHECK("eoc level", v, eoc)
	endtask

	task automatic conv_setup(input logic c);
		@(posedge clock_i);
		#1;
		comp_i = c;
		eoc_lo = 0;
		int_hi = 0;
	endtask

	task automatic read_result(output logic [19:0] r);
		logic [7:0] lo;
		logic [7:0] hi;
		sx(8'h00);
		sx(8'h04);
		lo = rd;
		sx(8'h02);
		hi = rd;
		sx(8'h02);
		st = rd;
		r = {st[3], hi, lo, st[2:0]};
	endtask

	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#500us;
		n_mismatch++;
		$display("unexpected run length: expected done, seen timeout");
		finish_test();
	end

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		rstn_i = 1'h0;
		comp_i = 1'h1;
		n_mismatch = 0;
		n_compared = 0;
		repeat (10) @(posedge clock_i);
		#1 rstn_i = 1'h1;
		`CHECK("reset outputs", 8'hA0, {eoc, integ, osc_run, read_zero, gp})
		repeat (3) @(posedge clock_i);
		sx(8'hA1);
		`CHECK("gp pins", 4'hA, gp)
		sx(8'h51);
		`CHECK("gp pins", 4'h5, gp)
		sx(8'h16);
		`CHECK("read zero set", 1'h1, read_zero)
		sx(8'h00);
		`CHECK("invalid select", 8'h00, rd)
		`CHECK("read zero clear", 1'h0, read_zero)
		conv_setup(1'h1);
		sx(8'h80);
		wait_eoc(1'h0, 20);
		wait_eoc(1'h1, 2100);
		`CHECK("eoc low cycles", 2047, eoc_lo)
		`CHECK("integrate 60", 546, int_hi)
		read_result(pos);
		`CHECK("pos range", 1'h1, (pos > 0 && pos[19] == 1'h0 && pos <= SAT))
		`CHECK("status flags", 3'h4, st[6:4])
		repeat (50) @(posedge clock_i);
		`CHECK("no restart", 1'h1, eoc)
		conv_setup(1'h0);
		sx(8'h80);
		wait_eoc(1'h0, 20);
		repeat (100) @(posedge clock_i);
		sx(8'h80);
		wait_eoc(1'h1, 2100);
		wait_eoc(1'h0, 6);
		wait_eoc(1'h1, 2100);
		`CHECK("eoc low cycles", 4094, eoc_lo)
		`CHECK("integrate 60", 1092, int_hi)
		repeat (50) @(posedge clock_i);
		`CHECK("start cleared", 1'h1, eoc)
		read_result(neg);
		`CHECK("neg result", 20'h0_0000 - pos, neg)
		`CHECK("sign bit", 1'h1, st[3])
		sx(8'h02);
		conv_setup(1'h1);
		sx(8'h82);
		for (int i = 0; i < 2100 && eoc_lo < 2000; i++) @(posedge clock_i);
		sx(8'h02);
		`CHECK("collision before", 1'h0, rd[7])
		sx(8'h02);
		`CHECK("collision set", 1'h1, rd[7])
		sx(8'h02);
		`CHECK("collision cleared", 1'h0, rd[7])
		conv_setup(1'h1);
		sx(8'hE0);
		wait_eoc(1'h0, 20);
		`CHECK("awake converting", 1'h1, osc_run)
		wait_eoc(1'h1, 2100);
		`CHECK("integrate 50", 655, int_hi)
		repeat (2) @(posedge clock_i);
		`CHECK("asleep", 1'h0, osc_run)
		sx(8'h22);
		sx(8'h22);
		`CHECK("sleep status", 3'h5, rd[6:4])
		sx(8'h00);
		`CHECK("awake again", 1'h1, osc_run)
		repeat (2048) @(posedge clock_i);
		conv_setup(1'h1);
		sx(8'h80);
		wait_eoc(1'h0, 20);
		wait_eoc(1'h1, 2100);
		read_result(res);
		`CHECK("repeat result", pos, res)
		// comparator flips early in the first deintegrate
		conv_setup(1'h1);
		sx(8'h80);
		wait_eoc(1'h0, 20);
		while (eoc_lo < 800) @(posedge clock_i);
		#1 comp_i = 1'h0;
		wait_eoc(1'h1, 2100);
		read_result(res);
		`CHECK("crossing result", 1'h1, (res > 0 && res[19] == 1'h0 && res < 20'h1_0000))
		finish_test();
	end
endmodule
